// [verilog/wdc_watchdog.sv]
`timescale 1ns/1ps
module wdc_watchdog
(
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    input  wire logic                 wdtEnable,
    input  wire logic                 wdtTick,
    input  wire logic                 refreshInstr,
    input  wire logic                 on_chip_debugger,
    input  wire logic                 stopMode,
    input  wire logic                 timeout_response_select,
    input  wire logic                 reloadWrite,
    input  wire logic [wdc_pkg::CNT_W-1:0] reloadIn,
    input  wire logic                 statusClear,
    output logic                      exceptionReq,
    output logic                      stopRecovery,
    output logic                      shortResetReq,
    output logic                      wdtStatusFlag,
    output logic                      stopStatusFlag,
    output logic [wdc_pkg::CNT_W-1:0] countValue,
    output logic [wdc_pkg::CNT_W-1:0] reloadValue
);
    import wdc_pkg::*;

    wdc_state_t             state_q;
    logic [CNT_W-1:0]       count_q;
    logic [CNT_W-1:0]       reload_q;
    logic [4:0]             rstCnt_q;
    logic                   exc_q;
    logic                   rec_q;
    logic                   srst_q;
    logic                   wdtFlag_q;
    logic                   stopFlag_q;
    logic                   refresh;
    logic                   timeout;
    logic                   toExc;
    logic                   toRst;

    // debugger mode looks like a refresh on every cycle
    assign refresh = refreshInstr || on_chip_debugger;
    // the tick that finds the counter at one is the time-out
    assign timeout = (state_q == WDC_COUNT) && !refresh && wdtTick
                     && (count_q == CNT_ONE);

    // response decode shared by every consumer, so they all agree on the same cycle
    function automatic logic timeoutWith(input logic toNow, input logic sel, input logic resp);
        return toNow && (sel == resp);
    endfunction : timeoutWith

    // the option bit turns a time-out into exactly one of the two responses
    assign toExc = timeoutWith(timeout, timeout_response_select, RESP_EXCEPTION);
    assign toRst = timeoutWith(timeout, timeout_response_select, RESP_RESET);

    // reload value store; a write takes effect at the next reload only
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            reload_q <= RELOAD_DEFAULT;
        else if (reloadWrite)
            reload_q <= reloadIn;
    end

    // main state machine
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            state_q <= WDC_IDLE;
        else
        begin
            case (state_q)
                WDC_IDLE:
                    if (wdtEnable)
                        state_q <= WDC_COUNT;
                WDC_COUNT:
                    if (!wdtEnable)
                        state_q <= WDC_IDLE;
                    else if (toRst)
                        state_q <= WDC_RESET;
                WDC_RESET:
                    if (rstCnt_q == RST_PULSE_ONE)
                        state_q <= WDC_IDLE;
                default:
                    state_q <= WDC_IDLE;
            endcase
        end
    end

    // down-counter; a reload wins over a tick in the same cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            count_q <= RELOAD_DEFAULT;
        else if (state_q == WDC_IDLE)
        begin
            if (wdtEnable)
                count_q <= reload_q;
        end
        else if (state_q == WDC_COUNT)
        begin
            if (refresh)
                count_q <= reload_q;
            else if (toExc)
                count_q <= reload_q;
            else if (wdtTick && count_q != CNT_ZERO)
                count_q <= count_q - CNT_ONE;
        end
    end

    // exception request to the interrupt controller, a one-cycle pulse
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            exc_q <= 1'b0;
        else
            exc_q <= toExc;
    end

    // stop-mode recovery pulse; only the exception response wakes the chip this way
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rec_q <= 1'b0;
        else
            rec_q <= toExc && stopMode;
    end

    // short reset request, held for a fixed count
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rstCnt_q <= RST_PULSE_ZERO;
            srst_q   <= 1'b0;
        end
        else if (toRst)
        begin
            rstCnt_q <= RST_PULSE_LEN;
            srst_q   <= 1'b1;
        end
        else if (rstCnt_q != RST_PULSE_ZERO)
        begin
            rstCnt_q <= rstCnt_q - RST_PULSE_ONE;
            srst_q   <= (rstCnt_q != RST_PULSE_ONE);
        end
        else
            srst_q <= 1'b0;
    end

    // sticky watchdog status flag; a new time-out wins over a clear
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            wdtFlag_q <= 1'b0;
        else if (timeout)
            wdtFlag_q <= 1'b1;
        else if (statusClear)
            wdtFlag_q <= 1'b0;
    end

    // stop flag on its own, so a clear is not lost beside a time-out outside stop mode
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            stopFlag_q <= 1'b0;
        else if (timeout && stopMode)
            stopFlag_q <= 1'b1;
        else if (statusClear)
            stopFlag_q <= 1'b0;
    end

    assign exceptionReq   = exc_q;
    assign stopRecovery   = rec_q;
    assign shortResetReq  = srst_q;
    assign wdtStatusFlag  = wdtFlag_q;
    assign stopStatusFlag = stopFlag_q;
    assign countValue     = count_q;
    assign reloadValue    = reload_q;

    // assertions
    // last tick of a running count: the cycle that finds the counter at one
    sequence s_lastTick;
        state_q == WDC_COUNT && wdtEnable && !refresh && wdtTick && count_q == CNT_ONE;
    endsequence

    // the same tick split by the selected response; the option bit picks exactly one
    sequence s_excTimeout;
        s_lastTick and (timeout_response_select == RESP_EXCEPTION);
    endsequence

    sequence s_rstTimeout;
        s_lastTick and (timeout_response_select == RESP_RESET);
    endsequence

    // an exception request stands one cycle only, so the controller sees one event
    sequence s_excOneCycle;
        exceptionReq ##1 !exceptionReq;
    endsequence

    // exception response: one pulse, automatic reload, nothing of the reset path
    a_excReload: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_excTimeout |=> count_q == $past(reload_q) && state_q == WDC_COUNT)
        else $error("no reload after exception time-out");
    a_excPulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_excTimeout |=> s_excOneCycle)
        else $error("exception request missing or too long");
    a_excOnlyTo: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(exceptionReq) |-> $past(count_q) == CNT_ONE)
        else $error("exception without counter reaching zero");
    a_excNoReset: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_excTimeout |=> !shortResetReq)
        else $error("short reset raised in exception mode");

    // stop mode: recovery rides on the exception, and both flags are set
    a_stopRecov: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_excTimeout and stopMode) |=> stopRecovery)
        else $error("stop recovery missing");
    a_excNoStop: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_excTimeout and !stopMode) |=> !stopRecovery)
        else $error("stop recovery outside stop mode");
    a_recWithExc: assert property (@(posedge clk_sys) disable iff (!rstn)
        stopRecovery |-> exceptionReq && $past(stopMode))
        else $error("stop recovery without exception in stop mode");
    a_stopFlags: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_lastTick and stopMode) |=> wdtStatusFlag && stopStatusFlag)
        else $error("status flags not set");
    a_wdtFlagSet: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_lastTick |=> wdtStatusFlag)
        else $error("watchdog flag not set on time-out");
    a_stopFlagSrc: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(stopStatusFlag) |-> $past(timeout) && $past(stopMode))
        else $error("stop flag set without time-out in stop mode");

    // a clear drops the flags unless a time-out sets them in that same cycle
    a_flagClear: assert property (@(posedge clk_sys) disable iff (!rstn)
        statusClear && !timeout |=> !wdtStatusFlag && !stopStatusFlag)
        else $error("status clear ignored");
    a_clearStop: assert property (@(posedge clk_sys) disable iff (!rstn)
        statusClear && !(timeout && stopMode) |=> !stopStatusFlag)
        else $error("stop flag clear lost");

    // reset response: fixed-length pulse, no exception, counter frozen, then idle
    a_resetPulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_rstTimeout |=> shortResetReq[*8])
        else $error("short reset too brief");
    a_rstNoExc: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_rstTimeout |=> !exceptionReq && !stopRecovery)
        else $error("exception raised in reset mode");
    a_rstLength: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_rstTimeout |=> rstCnt_q == RST_PULSE_LEN)
        else $error("short reset length not loaded");
    a_srstOnlyTo: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(shortResetReq) |-> $past(count_q) == CNT_ONE)
        else $error("short reset without counter reaching zero");
    a_resetEnds: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(shortResetReq) |-> ##[1:20] !shortResetReq)
        else $error("short reset never ends");
    a_pulseState: assert property (@(posedge clk_sys) disable iff (!rstn)
        shortResetReq |-> state_q == WDC_RESET)
        else $error("short reset outside reset state");
    a_pulseIdle: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(shortResetReq) |-> state_q == WDC_IDLE)
        else $error("no return to idle after short reset");
    a_rstCntIdle: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == WDC_IDLE |-> rstCnt_q == RST_PULSE_ZERO)
        else $error("pulse counter busy while idle");
    a_rstFreeze: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == WDC_RESET |=> $stable(count_q))
        else $error("counter moved during short reset");

    // refresh paths, first load and plain counting
    a_debugHold: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == WDC_COUNT && on_chip_debugger |=> count_q == $past(reload_q)
        && !exceptionReq)
        else $error("debugger refresh failed");
    a_refresh: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == WDC_COUNT && refreshInstr |=> count_q == $past(reload_q))
        else $error("refresh did not reload");
    a_firstLoad: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == WDC_IDLE && wdtEnable |=> count_q == $past(reload_q))
        else $error("first enable did not load");
    a_decrement: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == WDC_COUNT && wdtEnable && !refresh && wdtTick && count_q > CNT_ONE
        |=> count_q == $past(count_q) - CNT_ONE)
        else $error("counter did not decrement");
    a_refreshNoTo: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == WDC_COUNT && refreshInstr |=> !exceptionReq && !shortResetReq)
        else $error("time-out despite refresh");
    a_idleHold: assert property (@(posedge clk_sys) disable iff (!rstn)
        state_q == WDC_IDLE && !wdtEnable |=> $stable(count_q))
        else $error("counter moved while idle");
    a_reloadStore: assert property (@(posedge clk_sys) disable iff (!rstn)
        reloadWrite |=> reloadValue == $past(reloadIn))
        else $error("reload value not stored");
endmodule : wdc_watchdog

// [verilog/wdc_pkg.sv]
package wdc_pkg;
    localparam int            CNT_W          = 16;
    localparam logic [15:0]   RELOAD_DEFAULT = 16'h0400;
    localparam logic [15:0]   CNT_ZERO       = 16'h0000;
    localparam logic [15:0]   CNT_ONE        = 16'h0001;
    // length of the short reset pulse, in system clocks
    localparam int            RST_PULSE_CYC  = 16;
    localparam logic [4:0]    RST_PULSE_LEN  = 5'(RST_PULSE_CYC);
    localparam logic [4:0]    RST_PULSE_ZERO = 5'h00;
    localparam logic [4:0]    RST_PULSE_ONE  = 5'h01;
    localparam logic          RESP_EXCEPTION = 1'b0;
    localparam logic          RESP_RESET     = 1'b1;

    typedef enum logic [2:0]
    {
        WDC_IDLE  = 3'b001,
        WDC_COUNT = 3'b010,
        WDC_RESET = 3'b100
    } wdc_state_t;
endpackage : wdc_pkg

// [sim/wdc_cpu_model.sv]
`timescale 1ns/1ps
// stands in for the processor core and the interrupt controller
module wdc_cpu_model
(
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic refreshCmd,
    input  wire logic exceptionReq,
    output logic      refreshInstr,
    output int        excCount
);
    // refresh instruction issued one clock after the bench asks for it
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn) refreshInstr <= 1'b0;
        else       refreshInstr <= refreshCmd;
    // interrupt controller side: tally accepted exception requests
    always_ff @(posedge clk_sys or negedge rstn)
        if (!rstn)             excCount <= 0;
        else if (exceptionReq) excCount <= excCount + 1;
endmodule : wdc_cpu_model

// [sim/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import wdc_pkg::*;
    logic clk_sys, rstn, wdtEnable, wdtTick, refreshCmd, refreshInstr, dbg, stopMode;
    logic respSel, reloadWrite, statusClear, excReq, stopRec, shortRst, wdtFlag, stopFlag;
    logic [15:0] reloadIn, countValue, reloadValue;
    int errTotal = 0, checked = 0, excCount, n;
    wdc_cpu_model i_wdc_cpu_model (.clk_sys(clk_sys), .rstn(rstn), .refreshCmd(refreshCmd),
        .exceptionReq(excReq), .refreshInstr(refreshInstr), .excCount(excCount));
    wdc_watchdog i_wdc_watchdog (.clk_sys(clk_sys), .rstn(rstn), .wdtEnable(wdtEnable),
        .wdtTick(wdtTick), .refreshInstr(refreshInstr), .on_chip_debugger(dbg),
        .stopMode(stopMode), .timeout_response_select(respSel), .reloadWrite(reloadWrite),
        .reloadIn(reloadIn), .statusClear(statusClear), .exceptionReq(excReq),
        .stopRecovery(stopRec), .shortResetReq(shortRst), .wdtStatusFlag(wdtFlag),
        .stopStatusFlag(stopFlag), .countValue(countValue), .reloadValue(reloadValue));
    // counter and reload words
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // flag groups, four bits, padded by hand at the call
    task chkFlg(input logic [3:0] got, input logic [3:0] exp);
        checked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkFlg
    // ticks are strobed every other clock; returns just after the last sampling edge
    task tk(input int k);
        repeat (k)
        begin
            @(posedge clk_sys) wdtTick <= 1'b1;
            @(posedge clk_sys) wdtTick <= 1'b0;
        end
        #1;
    endtask : tk
    task cyc;
        @(posedge clk_sys);
        #1;
    endtask : cyc
    task t_count;
        chk(countValue, RELOAD_DEFAULT);
        chk(reloadValue, RELOAD_DEFAULT);
        @(posedge clk_sys) wdtEnable <= 1'b1;
        cyc();
        chk(countValue, RELOAD_DEFAULT);
        tk(1);
        chk(countValue, RELOAD_DEFAULT - 16'h0001);
        @(posedge clk_sys) dbg <= 1'b1;
        tk(3);
        chk(countValue, RELOAD_DEFAULT);
        chkFlg({3'h0, excReq}, 4'h0);
        @(posedge clk_sys) dbg <= 1'b0;
        $display("test count done");
    endtask : t_count
    task t_refresh;
        @(posedge clk_sys) reloadWrite <= 1'b1;
        @(posedge clk_sys) reloadWrite <= 1'b0;
        #1;
        chk(reloadValue, 16'h0003);
        @(posedge clk_sys) refreshCmd <= 1'b1;
        @(posedge clk_sys) refreshCmd <= 1'b0;
        cyc();
        chk(countValue, 16'h0003);
        tk(1);
        chk(countValue, 16'h0002);
        $display("test refresh done");
    endtask : t_refresh
    task t_exc;
        tk(2);
        chkFlg({excReq, stopRec, shortRst, wdtFlag}, 4'h9);
        chk(countValue, 16'h0003);
        cyc();
        chkFlg({3'h0, excReq}, 4'h0);
        chk(excCount[15:0], 16'h0001);
        @(posedge clk_sys) stopMode <= 1'b1;
        tk(3);
        chkFlg({excReq, stopRec, wdtFlag, stopFlag}, 4'hF);
        @(posedge clk_sys) statusClear <= 1'b1;
        @(posedge clk_sys) statusClear <= 1'b0;
        stopMode <= 1'b0;
        #1;
        chkFlg({2'h0, wdtFlag, stopFlag}, 4'h0);
        $display("test exception done");
    endtask : t_exc
    task t_rst;
        @(posedge clk_sys) respSel <= RESP_RESET;
        tk(3);
        chkFlg({1'h0, excReq, shortRst, wdtFlag}, 4'h3);
        n = 0;
        while (shortRst === 1'b1 && n < 40)
        begin
            n++;
            cyc();
        end
        chk(16'(n), 16'(RST_PULSE_CYC));
        $display("test short reset done");
    endtask : t_rst
    task summarize;
        $display("compares %0d mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // watchdog: the whole sequence needs well under 200 clocks
    initial
    begin
        #20000;
        errTotal++;
        summarize();
    end
    initial
    begin
        {rstn, wdtEnable, wdtTick, refreshCmd, dbg, stopMode, reloadWrite, statusClear} = '0;
        respSel = RESP_EXCEPTION;
        reloadIn = 16'h0003;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        cyc();
        t_count();
        t_refresh();
        t_exc();
        t_rst();
        summarize();
    end
endmodule : testbench
